// ==== common/tpg_pkg.sv ====
// Purpose: Constants and types for the three-port pin block
// Assumes: Word addressed register port, 8-bit address
// Notes: Register index = port * 8 + register number
package tpg_pkg;
  localparam int NUM_PORTS = 3;
  localparam int PORT_BITS = 8;
  localparam int NUM_PINS = 24;
  localparam int MODE_W = 4;
  localparam int ADDR_W = 8;
  // Register numbers inside one port's block of eight
  localparam logic [2:0] REG_LEVEL = 3'h0;
  localparam logic [2:0] REG_OUT = 3'h1;
  localparam logic [2:0] REG_CLR = 3'h2;
  localparam logic [2:0] REG_SET = 3'h3;
  localparam logic [2:0] REG_WAKE = 3'h4;
  localparam logic [2:0] REG_CFG_LO = 3'h5;
  localparam logic [2:0] REG_CFG_HI = 3'h6;
  // Block-wide control register
  localparam logic [ADDR_W-1:0] REG_ALT_SEL = 8'h18;
  // Reset values
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [31:0] CFG_RST = 32'h44444444;
  localparam logic [1:0] ALT_SEL_RST = 2'h0;
  // Mode codes
  localparam logic [3:0] MODE_ANALOG = 4'h0;
  localparam logic [3:0] MODE_OUT_PP = 4'h1;
  localparam logic [3:0] MODE_IN_FLOAT = 4'h4;
  localparam logic [3:0] MODE_OUT_OD = 4'h5;
  localparam logic [3:0] MODE_IN_PULL = 4'h8;
  localparam logic [3:0] MODE_ALT_PP = 4'h9;
  localparam logic [3:0] MODE_ALT_OD = 4'hd;
  // Pins of port a carrying trace
  localparam int TRACE_PIN_EN = 4;
  localparam int TRACE_PIN_DATA = 5;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tpg_req_s;

  // Pad controls for all pins
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
    logic [NUM_PINS-1:0] pull_up;
    logic [NUM_PINS-1:0] pull_dn;
  } tpg_pad_s;

  // Peripheral alternate output sources
  typedef struct packed {
    logic [NUM_PINS-1:0] data;
    logic [NUM_PINS-1:0] present;
    logic [NUM_PINS-1:0] data2;
    logic [NUM_PINS-1:0] present2;
  } tpg_alt_s;
endpackage

// ==== rtl/tpg_gpio.sv ====
// Purpose: Three-port general purpose pin block with register port
// Assumes: Pins and alternate sources arrive asynchronous to sys_clk
// Notes: Pads are four-signal (out, oe, pull_up, pull_dn); open-drain releases instead of driving high
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
module tpg_gpio (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register port
  input wire tpg_pkg::tpg_req_s req,
  output logic [31:0] rdata,
  // Pads
  input wire logic [tpg_pkg::NUM_PINS-1:0] pin_in,
  output tpg_pkg::tpg_pad_s pad,
  // Peripheral side
  input wire tpg_pkg::tpg_alt_s alt,
  input wire logic [tpg_pkg::NUM_PINS-1:0] serial_ctrl_use,
  input wire logic [1:0] packet_trace_in,
  input wire logic cpu_trace_bit2,
  input wire logic cpu_trace_bit3,
  output logic [tpg_pkg::NUM_PINS-1:0] alt_in,
  output logic [tpg_pkg::NUM_PINS-1:0] wake_hit
);
  import tpg_pkg::*;

  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] last_level;
  logic [NUM_PINS-1:0] out_reg;
  logic [NUM_PINS-1:0] wake_sel;
  logic [NUM_PINS*MODE_W-1:0] mode;
  logic [1:0] alt_sel;
  logic [NUM_PINS-1:0] alt_sync1;
  logic [NUM_PINS-1:0] alt_sync2;
  logic [NUM_PINS-1:0] alt2_sync1;
  logic [NUM_PINS-1:0] alt2_sync2;
  logic [3:0] trace_sync1;
  logic [3:0] trace_sync2;
  tpg_pad_s next_pad;
  logic [NUM_PINS-1:0] next_out;
  logic [31:0] next_rdata;
  logic [1:0] port_idx;
  logic [2:0] reg_idx;
  logic port_ok;
  logic [6:0] cfg_base;

  assign port_idx = req.addr[4:3];
  // Each port owns 32 mode bits: eight pins of four bits
  assign cfg_base = {port_idx, 5'h0};
  assign reg_idx = req.addr[2:0];
  assign port_ok = (req.addr[ADDR_W-1:5] == 3'h0) && (port_idx != 2'h3);

  // Two-stage synchronisers for pins and peripheral sources
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      alt_sync1 <= '0;
      alt_sync2 <= '0;
      alt2_sync1 <= '0;
      alt2_sync2 <= '0;
      trace_sync1 <= '0;
      trace_sync2 <= '0;
    end else if (clk_en) begin
      sync1 <= pin_in;
      sync2 <= sync1;
      alt_sync1 <= alt.data;
      alt_sync2 <= alt_sync1;
      alt2_sync1 <= alt.data2;
      alt2_sync2 <= alt2_sync1;
      trace_sync1 <= {cpu_trace_bit3, cpu_trace_bit2, packet_trace_in};
      trace_sync2 <= trace_sync1;
    end
  end

  // Per-pin input gating and pad control
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic [3:0] m;
      logic src;
      assign m = mode[gi*MODE_W +: MODE_W];
      // Analog pins see a forced high input
      assign level[gi] = (m == MODE_ANALOG) ? 1'b1 : sync2[gi];
      // Alternate source: trace mux, second peripheral, first peripheral, or constant low
      always_comb begin
        if (gi == TRACE_PIN_EN && alt_sel[0]) begin
          src = trace_sync2[2];
        end else if (gi == TRACE_PIN_DATA && alt_sel[0]) begin
          src = trace_sync2[3];
        end else if (gi == TRACE_PIN_EN) begin
          src = trace_sync2[0];
        end else if (gi == TRACE_PIN_DATA) begin
          src = trace_sync2[1];
        end else if (alt_sel[1] && alt.present2[gi]) begin
          src = alt2_sync2[gi];
        end else if (alt.present[gi] && serial_ctrl_use[gi]) begin
          src = alt_sync2[gi];
        end else begin
          src = 1'b0;
        end
      end
      // Pad drive by mode
      always_comb begin
        next_pad.out[gi] = 1'b0;
        next_pad.oe[gi] = 1'b0;
        next_pad.pull_up[gi] = 1'b0;
        next_pad.pull_dn[gi] = 1'b0;
        case (m)
          MODE_OUT_PP: begin
            next_pad.out[gi] = out_reg[gi];
            next_pad.oe[gi] = 1'b1;
          end
          MODE_OUT_OD: begin
            next_pad.oe[gi] = !out_reg[gi];
          end
          MODE_ALT_PP: begin
            next_pad.out[gi] = src;
            next_pad.oe[gi] = 1'b1;
          end
          MODE_ALT_OD: begin
            next_pad.oe[gi] = !src;
          end
          MODE_IN_PULL: begin
            next_pad.pull_up[gi] = out_reg[gi];
            next_pad.pull_dn[gi] = !out_reg[gi];
          end
          default: begin
            next_pad.out[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // Registered pad drive and input fan-out
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pad <= '0;
      alt_in <= '0;
      last_level <= '1;
    end else if (clk_en) begin
      pad <= next_pad;
      alt_in <= level;
      last_level <= level;
    end
  end

  // Wake events only from selected pins that change
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_hit <= '0;
    end else if (clk_en) begin
      wake_hit <= wake_sel & (level ^ last_level);
    end
  end

  // Output register next value: write, then clear, then set
  always_comb begin
    next_out = out_reg;
    if (req.wr && port_ok) begin
      if (reg_idx == REG_OUT) begin
        next_out[port_idx*PORT_BITS +: PORT_BITS] = req.wdata[7:0];
      end else if (reg_idx == REG_CLR) begin
        next_out[port_idx*PORT_BITS +: PORT_BITS] =
          out_reg[port_idx*PORT_BITS +: PORT_BITS] & ~req.wdata[7:0];
      end else if (reg_idx == REG_SET) begin
        next_out[port_idx*PORT_BITS +: PORT_BITS] =
          out_reg[port_idx*PORT_BITS +: PORT_BITS] | req.wdata[7:0];
      end
    end
  end

  // Output register update; one write per cycle keeps order
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_reg <= {NUM_PORTS{OUT_RST}};
    end else if (clk_en) begin
      out_reg <= next_out;
    end
  end

  // Wake select, mode and trace select registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_sel <= {NUM_PORTS{WAKE_RST}};
      mode <= {NUM_PORTS{CFG_RST}};
      alt_sel <= ALT_SEL_RST;
    end else if (clk_en && req.wr) begin
      if (req.addr == REG_ALT_SEL) begin
        alt_sel <= req.wdata[1:0];
      end else if (port_ok && reg_idx == REG_WAKE) begin
        wake_sel[port_idx*PORT_BITS +: PORT_BITS] <= req.wdata[7:0];
      end else if (port_ok && reg_idx == REG_CFG_LO) begin
        mode[cfg_base +: 16] <= req.wdata[15:0];
      end else if (port_ok && reg_idx == REG_CFG_HI) begin
        mode[cfg_base+16 +: 16] <= req.wdata[15:0];
      end
    end
  end

  // Read mux; unmapped and write-only read as zero
  always_comb begin
    next_rdata = 32'h0;
    if (req.addr == REG_ALT_SEL) begin
      next_rdata = {30'h0, alt_sel};
    end else if (port_ok && reg_idx == REG_LEVEL) begin
      next_rdata = {24'h0, level[port_idx*PORT_BITS +: PORT_BITS]};
    end else if (port_ok && reg_idx == REG_OUT) begin
      next_rdata = {24'h0, out_reg[port_idx*PORT_BITS +: PORT_BITS]};
    end else if (port_ok && reg_idx == REG_WAKE) begin
      next_rdata = {24'h0, wake_sel[port_idx*PORT_BITS +: PORT_BITS]};
    end else if (port_ok && reg_idx == REG_CFG_LO) begin
      next_rdata = {16'h0, mode[cfg_base +: 16]};
    end else if (port_ok && reg_idx == REG_CFG_HI) begin
      next_rdata = {16'h0, mode[cfg_base+16 +: 16]};
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else if (clk_en) begin
      rdata <= req.rd ? next_rdata : 32'h0;
    end
  end

  // Assertions
  a_set_bits_stick: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && req.wr && req.addr == 8'h03 && req.wdata[0] |=>
      out_reg[0])
    else $error("set write failed");
  a_od_never_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && mode[7:4] == MODE_OUT_OD |=>
      !pad.out[1] && pad.oe[1] == !$past(out_reg[1]))
    else $error("open drain drove high");
  a_analog_no_pull: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && mode[3:0] == MODE_ANALOG |=>
      !pad.pull_up[0] && !pad.pull_dn[0] && !pad.oe[0])
    else $error("analog pin has pull or drive");
  a_input_no_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && mode[3:0] == MODE_IN_FLOAT |=> !pad.oe[0])
    else $error("input pin driven");
  a_pp_follows_reg: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && mode[3:0] == MODE_OUT_PP |=>
      pad.oe[0] && pad.out[0] == $past(out_reg[0]))
    else $error("push-pull pin not following register");
  a_pull_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && mode[3:0] == MODE_IN_PULL |=>
      pad.pull_up[0] == $past(out_reg[0]) &&
      pad.pull_dn[0] == !$past(out_reg[0]))
    else $error("pull direction wrong");
  a_clear_bit0: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && req.wr && req.addr == 8'h02 && req.wdata[0] |=>
      !out_reg[0])
    else $error("clear write failed");
  a_read_one_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
    clk_en && !req.rd |=> rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // tpg_gpio

// ==== verif/tpg_pad_model.sv ====
// Purpose: Board-side pin model for the three-port pin block
// Assumes: The bench never drives a pin that the block also drives
// Notes: A released pin with no pull reads high through a board pull-up
`timescale 1ns/1ps
module tpg_pad_model (
  // Pad controls from the block
  input wire tpg_pkg::tpg_pad_s pad,
  // External drivers set by the bench
  input wire logic [tpg_pkg::NUM_PINS-1:0] ext,
  input wire logic [tpg_pkg::NUM_PINS-1:0] ext_en,
  // Resolved pin levels
  output logic [tpg_pkg::NUM_PINS-1:0] pin_in
);
  import tpg_pkg::*;
  // Block drive first, then board drive, then pulls, then board pull-up
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad.oe[i]) begin
        pin_in[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext[i];
      end else if (pad.pull_dn[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule // tpg_pad_model

// ==== verif/tb_three_port_gpio_block.sv ====
// Purpose: Self-checking bench for the three-port pin block
// Assumes: Strobes driven by NBA right after rising edges
// Notes: Pin waits exceed the two and three cycle sync paths
`timescale 1ns/1ps
module tb_three_port_gpio_block;
  import tpg_pkg::*;
  logic sys_clk, nrst, clk_en, cpu_trace_bit2, cpu_trace_bit3;
  tpg_req_s req;
  tpg_pad_s pad;
  tpg_alt_s alt;
  logic [31:0] rdata;
  logic [1:0] packet_trace_in;
  logic [NUM_PINS-1:0] pin_in, ext, ext_en, serial_ctrl_use, alt_in, wake_hit;
  int err_total, n_compared;

  tpg_gpio DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .req(req),
    .rdata(rdata), .pin_in(pin_in), .pad(pad), .alt(alt),
    .serial_ctrl_use(serial_ctrl_use), .packet_trace_in(packet_trace_in),
    .cpu_trace_bit2(cpu_trace_bit2), .cpu_trace_bit3(cpu_trace_bit3),
    .alt_in(alt_in), .wake_hit(wake_hit));
  tpg_pad_model pins (.pad(pad), .ext(ext), .ext_en(ext_en), .pin_in(pin_in));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Reset values and unmapped places
  task automatic t_reset;
    logic [31:0] d;
    rd(8'h0e, d);
    chk("cfg b high", 32'h4444, {16'h0, d[15:0]});
    rd(8'h01, d);
    chk("out a", 32'h0, d);
    rd(8'h1f, d);
    chk("unmapped", 32'h0, d);
  endtask
  // Port a pins 0..3: push-pull, open-drain, pulled, analog
  task automatic t_out;
    logic [31:0] d;
    wr(8'h05, 32'h0851);
    wr(8'h03, 32'h0f);
    wait_clk(4);
    chk("oe a", 32'h1, {28'h0, pad.oe[3:0]});
    chk("drive a0", 32'h1, {31'h0, pad.out[0]});
    chk("pull up a", 32'h4, {28'h0, pad.pull_up[3:0]});
    chk("pull dn a", 32'h0, {28'h0, pad.pull_dn[3:0]});
    rd(8'h01, d);
    chk("out a set", 32'h0f, d);
    rd(8'h00, d);
    chk("level a", 32'hff, d);
    wr(8'h02, 32'h07);
    wait_clk(4);
    chk("oe a od", 32'h3, {28'h0, pad.oe[3:0]});
    chk("drive a1a0", 32'h0, {30'h0, pad.out[1:0]});
    chk("pull dn a2", 32'h4, {28'h0, pad.pull_dn[3:0]});
    rd(8'h00, d);
    chk("level a clr", 32'hf8, d);
    @(posedge sys_clk);
    req <= '{addr: 8'h03, wdata: 32'h80, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req <= '{addr: 8'h02, wdata: 32'h80, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    req.wr <= 1'b0;
    rd(8'h01, d);
    chk("out a order", 32'h08, d);
  endtask
  // Enable low freezes state: a set write is lost
  task automatic t_freeze;
    logic [31:0] d;
    clk_en <= 1'b0;
    wr(8'h03, 32'h40);
    clk_en <= 1'b1;
    rd(8'h01, d);
    chk("out a frozen", 32'h08, d);
  endtask
  // Alternate sources on port b pin 0 and trace on port a pins 4, 5
  task automatic t_alt;
    @(posedge sys_clk);
    alt <= '{data: 24'h100, present: 24'h100, data2: 24'h0, present2: 24'h100};
    serial_ctrl_use <= 24'h100;
    packet_trace_in <= 2'b11;
    wr(8'h0d, 32'h9);
    wr(8'h06, 32'h0099);
    wait_clk(5);
    chk("alt b0", 32'h3, {30'h0, pad.oe[8], pad.out[8]});
    chk("alt in b0", 32'h1, {31'h0, alt_in[8]});
    chk("trace pkt", 32'h3, {30'h0, pad.out[5:4]});
    wr(8'h18, 32'h3);
    wait_clk(5);
    chk("second src", 32'h0, {31'h0, pad.out[8]});
    chk("trace cpu", 32'h0, {30'h0, pad.out[5:4]});
    wr(8'h18, 32'h0);
    serial_ctrl_use <= 24'h0;
    wait_clk(5);
    chk("serial mode", 32'h0, {31'h0, pad.out[8]});
    serial_ctrl_use <= 24'h100;
    alt.present <= 24'h0;
    wait_clk(5);
    chk("no source", 32'h0, {31'h0, pad.out[8]});
  endtask
  // Wake on port c pin 0 selected, pin 1 not
  task automatic t_wake;
    int h16, h17;
    h16 = 0;
    h17 = 0;
    wr(8'h14, 32'h1);
    wait_clk(6);
    ext <= 24'h0;
    repeat (10) begin
      wait_clk(1);
      if (wake_hit[16] === 1'b1) h16++;
      if (wake_hit[17] !== 1'b0) h17++;
    end
    chk("wake sel", 32'h1, h16);
    chk("wake unsel", 32'h0, h17);
  endtask

  // Print counts and verdict, then stop
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Clock at 25 ns period
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the expected run
  initial begin
    #(25 * 4000);
    err_total++;
    report_and_stop;
  end
  // Main sequence
  initial begin
    req = '0;
    clk_en = 1'b1;
    alt = '0;
    ext = 24'h030000;
    ext_en = 24'h030008;
    serial_ctrl_use = '0;
    packet_trace_in = 2'b00;
    cpu_trace_bit2 = 1'b0;
    cpu_trace_bit3 = 1'b0;
    nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_out;
    t_freeze;
    t_alt;
    t_wake;
    report_and_stop;
  end
endmodule // tb_three_port_gpio_block
